// ==== core/avmd_defs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef AVMD_DEFS_SVH
`define AVMD_DEFS_SVH
`define AVMD_CTRL_OFS        4'h0
`define AVMD_THRESH_OFS      4'h4
`define AVMD_STATUS_OFS      4'h8
`define AVMD_VOL_LSB         0
`define AVMD_FADE_LSB        8
`define AVMD_MUTE_BIT        11
`define AVMD_POL_BIT         12
`define AVMD_TYPE_BIT        13
`define AVMD_OPMODE_LSB      14
`define AVMD_PGA_LSB         16
`define AVMD_SOUND_LSB       0
`define AVMD_SILENCE_LSB     4
`define AVMD_CTRL_RST        32'h0003_0000
`define AVMD_CTRL_MASK       32'h0007_ffff
`define AVMD_THRESH_RST      32'h0000_0000
`define AVMD_THRESH_MASK     32'h0000_00ff
`define AVMD_HPF_SHIFT       12
`define AVMD_GAIN_INF        8'hff
`define AVMD_FADE_DIRECT     3'h7
`define AVMD_OPMODE_LOWRATE  2'h2
`define AVMD_HOLDOFF_SAMPLES 32768
`define AVMD_DET_WINDOW      256
`endif

// ==== core/avmd_pkg.sv ====
// Shared types of the volume and presence detection block
`default_nettype none
package avmd_pkg;
    typedef logic signed [23:0] avmd_sample_type;
    typedef enum logic [1:0] {FADE_IDLE, FADE_DOWN, FADE_UP} avmd_fade_type;
endpackage
`default_nettype wire

// ==== core/avmd_smp_if.sv ====
// Stereo sample stream between the block's stages
`default_nettype none
interface avmd_smp_if;
    logic                      valid;
    avmd_pkg::avmd_sample_type left;
    avmd_pkg::avmd_sample_type right;
    modport src (output valid, output left, output right);
    modport dst (input valid, input left, input right);
endinterface
`default_nettype wire

// ==== core/avmd_hpf.sv ====
// DC-cancelling first-order high-pass filter for both channels
`include "avmd_defs.svh"
`default_nettype none
module avmd_hpf #(
    parameter int SHIFT = `AVMD_HPF_SHIFT
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Streams
    avmd_smp_if.dst  din,
    avmd_smp_if.src  dout
);
    localparam int FRAC = 12;
    if (SHIFT < 4 || SHIFT > FRAC) begin : g_bad_shift
        $error("HPF shift out of range");
    end
    avmd_pkg::avmd_sample_type x_in [2];
    avmd_pkg::avmd_sample_type y_out [2];
    logic                      vld_reg;
    assign x_in[0] = din.left;
    assign x_in[1] = din.right;
    // Corner is fs / (2 pi 2^SHIFT): 1.87 Hz at 48 kHz, tracks fs
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic signed [36:0] dc_reg, dc_next;
        logic signed [37:0] diff;
        logic signed [24:0] y_full;
        logic signed [23:0] y_reg, y_next;
        always_comb begin
            diff    = (38'(x_in[c]) <<< FRAC) - 38'(dc_reg);
            dc_next = din.valid ? dc_reg + 37'(diff >>> SHIFT) : dc_reg;
            y_full  = 25'(x_in[c]) - 25'(dc_reg >>> FRAC);
            y_next  = y_reg;
            if (din.valid) begin
                if (y_full > 25'sh07fffff) begin
                    y_next = 24'sh7fffff;
                end else if (y_full < -25'sh0800000) begin
                    y_next = -24'sh800000;
                end else begin
                    y_next = y_full[23:0];
                end
            end
        end
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                dc_reg <= '0;
                y_reg  <= '0;
            end else begin
                dc_reg <= dc_next;
                y_reg  <= y_next;
            end
        end
        assign y_out[c] = y_reg;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vld_reg <= 1'b0;
        end else begin
            vld_reg <= din.valid;
        end
    end
    assign dout.valid = vld_reg;
    assign dout.left  = y_out[0];
    assign dout.right = y_out[1];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    AST_HPF_LATENCY: assert property (din.valid |=> dout.valid)
        else $error("Filtered sample not produced one cycle after input");
endmodule
`default_nettype wire

// ==== core/avmd_gain.sv ====
// Digital volume: 0.25 dB per code on both channels, zero at full attenuation
`include "avmd_defs.svh"
`default_nettype none
module avmd_gain (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // Applied gain code
    input wire logic [7:0] gain_code,
    // Streams
    avmd_smp_if.dst        din,
    avmd_smp_if.src        dout
);
    // 10^(-0.25 r / 20) in Q16; each 24 codes halve the gain by a shift
    localparam logic [16:0] MANT [24] = '{
        17'h10000, 17'h0f8bd, 17'h0f1ae, 17'h0ead3, 17'h0e429, 17'h0ddb0,
        17'h0d766, 17'h0d149, 17'h0cb59, 17'h0c594, 17'h0bff9, 17'h0ba87,
        17'h0b53c, 17'h0b017, 17'h0ab18, 17'h0a63e, 17'h0a186, 17'h09cf1,
        17'h0987d, 17'h09429, 17'h08ff5, 17'h08be0, 17'h087e8, 17'h0840d};
    logic [7:0]                octave;
    logic [7:0]                step;
    avmd_pkg::avmd_sample_type x_in [2];
    avmd_pkg::avmd_sample_type y_out [2];
    logic                      vld_reg;
    assign octave  = gain_code / 8'h18;
    assign step    = gain_code % 8'h18;
    assign x_in[0] = din.left;
    assign x_in[1] = din.right;
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic signed [41:0] prod, sc;
        logic signed [23:0] y_reg, y_next;
        always_comb begin
            prod   = 42'(x_in[c]) * 42'($signed({1'b0, MANT[step[4:0]]}));
            sc     = prod >>> (16 + int'(octave));
            y_next = y_reg;
            if (din.valid) begin
                if (gain_code == `AVMD_GAIN_INF) begin
                    y_next = '0;
                end else if (sc > 42'sh7fffff) begin
                    y_next = 24'sh7fffff;
                end else if (sc < -42'sh800000) begin
                    y_next = -24'sh800000;
                end else begin
                    y_next = sc[23:0];
                end
            end
        end
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                y_reg <= '0;
            end else begin
                y_reg <= y_next;
            end
        end
        assign y_out[c] = y_reg;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            vld_reg <= 1'b0;
        end else begin
            vld_reg <= din.valid;
        end
    end
    assign dout.valid = vld_reg;
    assign dout.left  = y_out[0];
    assign dout.right = y_out[1];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    AST_ZERO_AT_INF: assert property (
        din.valid && gain_code == `AVMD_GAIN_INF
        |=> dout.valid && dout.left == '0 && dout.right == '0)
        else $error("Sample not zero at full attenuation");
endmodule
`default_nettype wire

// ==== core/avmd_volume_detect.sv ====
// Volume, soft mute and presence detection stage behind the stereo converter
////////////////////////////////////////////////////////////////////////////
// Behaviour
// - High-pass removes DC, corner scales with fs
// - Volume code: 0.25 dB steps, FFh silences
// - Volume changes ramp in 0.25 dB steps
// - Fade pace 1,2,4,8,16 samples or direct
// - Soft mute ramps down, then outputs zero
// - Mute released mid-ramp: gain ramps back up
// - Mute set mid-release: ramps back down
// - Detect only while converter is running
// - Type bit picks sound or silence detection
// - Sound threshold -60 to -30 dBFS, 2 dB
// - Silence threshold: own field, same range
// - Judge filtered samples; pin and status bit
// - Sound mode: flag high above threshold
// - Silence mode: flag low below threshold
// - Polarity bit inverts pin; status mirrors pin
// - Flag low whenever converter is stopped
// - Front-end gain -4.5 to +6 dB, 1.5 dB
// - Result held off 32768 samples after start
////////////////////////////////////////////////////////////////////////////
`include "avmd_defs.svh"
`default_nettype none
module avmd_volume_detect #(
    parameter int HOLDOFF_SAMPLES = `AVMD_HOLDOFF_SAMPLES,
    parameter int DET_WINDOW      = `AVMD_DET_WINDOW
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Converter side
    input  wire logic        conv_active,
    input  wire logic        adc_valid,
    input  wire logic [23:0] adc_left,
    input  wire logic [23:0] adc_right,
    output logic [1:0]       converter_operation_mode,
    output logic [2:0]       frontend_gain_select,
    // Serial output side
    output logic             out_valid,
    output logic [23:0]      out_left,
    output logic [23:0]      out_right,
    // Flag pin
    output logic             presence_flag_out
);
    localparam int HW = $clog2(HOLDOFF_SAMPLES + 1);
    localparam int WW = $clog2(DET_WINDOW);
    // Linear full-scale levels for -60 .. -30 dBFS in 2 dB steps
    localparam logic [23:0] THR_LEVEL [16] = '{
        24'h0020c5, 24'h002941, 24'h0033ef, 24'h004162,
        24'h00524f, 24'h00679f, 24'h008274, 24'h00a43b,
        24'h00cec1, 24'h010449, 24'h0147ae, 24'h019c86,
        24'h020756, 24'h028dd0, 24'h03371d, 24'h040c37};

    if (HOLDOFF_SAMPLES < 1 || DET_WINDOW < 2
        || (DET_WINDOW & (DET_WINDOW - 1)) != 0) begin : g_bad_param
        $error("Detector hold-off or window not supported");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0]             ctrl_reg, ctrl_next;
    logic [31:0]             thr_reg, thr_next;
    logic [31:0]             rdata_reg, rdata_next;
    logic                    rack_reg, rack_next;
    logic [31:0]             status;
    logic [7:0]              vol;
    logic [2:0]              fade;
    logic                    mute;
    logic                    pol;
    logic                    dtype;
    logic [1:0]              opmode;
    logic [7:0]              gain_reg, gain_next;
    logic [7:0]              target;
    logic [3:0]              pace_reg, pace_next;
    logic [4:0]              period;
    avmd_pkg::avmd_fade_type fst_reg, fst_next;
    logic [HW-1:0]           hold_reg, hold_next;
    logic [WW-1:0]           win_reg, win_next;
    logic                    above_reg, above_next;
    logic                    dec_reg, dec_next;
    logic                    flag_reg, flag_next;
    logic                    hold_done;
    logic                    hit;
    logic                    lowrate_silence;
    logic [23:0]             abs_l, abs_r, thr_lvl;

    avmd_smp_if s_in ();
    avmd_smp_if s_hpf ();
    avmd_smp_if s_out ();

    ////////////////////////////////////////////////////////////////////////
    // Sample path: filter, then volume
    assign s_in.valid = adc_valid && conv_active;
    assign s_in.left  = adc_left;
    assign s_in.right = adc_right;

    avmd_hpf u_hpf (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .din     (s_in),
        .dout    (s_hpf)
    );

    avmd_gain u_gain (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .gain_code (gain_reg),
        .din       (s_hpf),
        .dout      (s_out)
    );

    assign out_valid = s_out.valid;
    assign out_left  = s_out.left;
    assign out_right = s_out.right;

    ////////////////////////////////////////////////////////////////////////
    // Register file and bus
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r & mask;
    endfunction

    assign vol    = ctrl_reg[`AVMD_VOL_LSB +: 8];
    assign fade   = ctrl_reg[`AVMD_FADE_LSB +: 3];
    assign mute   = ctrl_reg[`AVMD_MUTE_BIT];
    assign pol    = ctrl_reg[`AVMD_POL_BIT];
    assign dtype  = ctrl_reg[`AVMD_TYPE_BIT];
    assign opmode = ctrl_reg[`AVMD_OPMODE_LSB +: 2];
    assign status = {15'h0000, dec_reg, gain_reg, 4'h0, fst_reg, hold_done, flag_reg};

    always_comb begin
        ctrl_next  = ctrl_reg;
        thr_next   = thr_reg;
        rdata_next = rdata_reg;
        rack_next  = avs_read && !rack_reg;
        if (avs_write) begin
            if (avs_address == `AVMD_CTRL_OFS) begin
                ctrl_next = merge(ctrl_reg, avs_writedata, avs_byteenable, `AVMD_CTRL_MASK);
            end else if (avs_address == `AVMD_THRESH_OFS) begin
                thr_next = merge(thr_reg, avs_writedata, avs_byteenable, `AVMD_THRESH_MASK);
            end
        end
        // One wait state on reads so that read data come from a flip-flop
        if (avs_read && !rack_reg) begin
            if (avs_address == `AVMD_CTRL_OFS) begin
                rdata_next = ctrl_reg;
            end else if (avs_address == `AVMD_THRESH_OFS) begin
                rdata_next = thr_reg;
            end else if (avs_address == `AVMD_STATUS_OFS) begin
                rdata_next = status;
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg  <= `AVMD_CTRL_RST;
            thr_reg   <= `AVMD_THRESH_RST;
            rdata_reg <= 32'h0000_0000;
            rack_reg  <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            thr_reg   <= thr_next;
            rdata_reg <= rdata_next;
            rack_reg  <= rack_next;
        end
    end

    assign avs_waitrequest          = avs_read && !rack_reg;
    assign avs_readdata             = rdata_reg;
    assign converter_operation_mode = opmode;
    assign frontend_gain_select     = ctrl_reg[`AVMD_PGA_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // Fade engine: applied code walks one step per pace toward target, or jumps to it when fade is direct
    assign target = mute ? `AVMD_GAIN_INF : vol;

    always_comb begin
        case (fade)
            3'h0: period = 5'h01;
            3'h1: period = 5'h02;
            3'h2: period = 5'h04;
            3'h3: period = 5'h08;
            default: period = 5'h10;
        endcase
    end

    always_comb begin
        gain_next = gain_reg;
        pace_next = pace_reg;
        fst_next  = avmd_pkg::FADE_IDLE;
        if (gain_reg < target) begin
            fst_next = avmd_pkg::FADE_DOWN;
        end else if (gain_reg > target) begin
            fst_next = avmd_pkg::FADE_UP;
        end
        // Target is re-read each step, so a mute toggle reverses mid-ramp
        if (gain_reg == target) begin
            pace_next = 4'h0;
        end else if (s_hpf.valid) begin
            if (fade == `AVMD_FADE_DIRECT) begin
                gain_next = target;
                pace_next = 4'h0;
            end else if ({1'b0, pace_reg} + 5'h01 >= period) begin
                pace_next = 4'h0;
                if (gain_reg < target) begin
                    gain_next = gain_reg + 8'h01;
                end else begin
                    gain_next = gain_reg - 8'h01;
                end
            end else begin
                pace_next = pace_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gain_reg <= 8'h00;
            pace_reg <= 4'h0;
            fst_reg  <= avmd_pkg::FADE_IDLE;
        end else begin
            gain_reg <= gain_next;
            pace_reg <= pace_next;
            fst_reg  <= fst_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Presence detector on filtered samples
    // A windowed peak avoids the flag chattering at zero crossings
    assign abs_l     = s_hpf.left[23] ? 24'(-s_hpf.left) : 24'(s_hpf.left);
    assign abs_r     = s_hpf.right[23] ? 24'(-s_hpf.right) : 24'(s_hpf.right);
    assign thr_lvl   = dtype ? THR_LEVEL[thr_reg[`AVMD_SOUND_LSB +: 4]]
                             : THR_LEVEL[thr_reg[`AVMD_SILENCE_LSB +: 4]];
    assign hit       = (abs_l > thr_lvl) || (abs_r > thr_lvl);
    assign hold_done = hold_reg == HW'(HOLDOFF_SAMPLES);
    // Silence detection has no low-rate form
    assign lowrate_silence = !dtype && opmode == `AVMD_OPMODE_LOWRATE;

    always_comb begin
        hold_next  = hold_reg;
        win_next   = win_reg;
        above_next = above_reg;
        dec_next   = dec_reg;
        if (!conv_active) begin
            hold_next  = '0;
            win_next   = '0;
            above_next = 1'b0;
            dec_next   = 1'b0;
        end else if (s_hpf.valid) begin
            if (!hold_done) begin
                hold_next = hold_reg + 1'b1;
            end else if (win_reg == WW'(DET_WINDOW - 1)) begin
                dec_next   = above_reg || hit;
                win_next   = '0;
                above_next = 1'b0;
            end else begin
                win_next   = win_reg + 1'b1;
                above_next = above_reg || hit;
            end
        end
        if (lowrate_silence) begin
            dec_next = 1'b0;
        end
        flag_next = conv_active ? dec_reg ^ pol : 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hold_reg  <= '0;
            win_reg   <= '0;
            above_reg <= 1'b0;
            dec_reg   <= 1'b0;
            flag_reg  <= 1'b0;
        end else begin
            hold_reg  <= hold_next;
            win_reg   <= win_next;
            above_reg <= above_next;
            dec_reg   <= dec_next;
            flag_reg  <= flag_next;
        end
    end

    assign presence_flag_out = flag_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    AST_FLAG_STOPPED: assert property (!conv_active |=> !presence_flag_out)
        else $error("Flag not low while converter stopped");
    AST_STEP_QUARTER: assert property (
        gain_reg != $past(gain_reg) && $past(fade) != `AVMD_FADE_DIRECT
        |-> gain_reg == $past(gain_reg) + 8'h01 || gain_reg == $past(gain_reg) - 8'h01)
        else $error("Gain moved by more than one step");
    AST_DIRECT_JUMP: assert property (
        s_hpf.valid && fade == `AVMD_FADE_DIRECT && gain_reg != target
        |=> gain_reg == $past(target))
        else $error("Direct slope did not jump to target");
    AST_PACE_ONE: assert property (
        s_hpf.valid && fade == 3'h0 && gain_reg != target |=> gain_reg != $past(gain_reg))
        else $error("Fastest slope skipped a sample");
    AST_MUTE_DOWN: assert property (
        $past(mute) && gain_reg != $past(gain_reg) |-> gain_reg > $past(gain_reg))
        else $error("Gain rose while muting");
    AST_RELEASE_UP: assert property (
        !$past(mute) && $past(vol) < $past(gain_reg) && gain_reg != $past(gain_reg)
        |-> gain_reg < $past(gain_reg))
        else $error("Gain fell during mute release");
    AST_HOLDOFF_QUIET: assert property (!hold_done |-> !dec_reg)
        else $error("Detection reported during hold-off");
    AST_SILENCE_LOWRATE: assert property (lowrate_silence |=> !dec_reg)
        else $error("Silence detection active in low-rate mode");
    AST_STATUS_MIRROR: assert property (
        avs_read && !avs_waitrequest && avs_address == `AVMD_STATUS_OFS
        |-> avs_readdata[0] == $past(presence_flag_out))
        else $error("Status bit does not mirror the flag pin");

    COV_MUTE_FLOOR: cover property (mute && gain_reg == `AVMD_GAIN_INF);
    COV_FLAG_RISE: cover property ($rose(presence_flag_out));
    COV_RELEASE_MID: cover property ($fell(mute) && gain_reg != `AVMD_GAIN_INF
                                     && gain_reg != vol);
endmodule
`default_nettype wire

// ==== verif/avmd_sink.sv ====
// Serial audio consumer model: counts delivered stereo frames
`default_nettype none
module avmd_sink (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // Stream from the block
    input wire logic        out_valid,
    input wire logic [23:0] out_left,
    input wire logic [23:0] out_right,
    // Observed results
    output var int          frame_count,
    output var logic [23:0] last_left
);
    timeunit 1ns;
    timeprecision 1ns;
    // Latches on the frame strobe only, like a real consumer; data between strobes is ignored
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frame_count <= 0;
            last_left   <= 24'h0;
        end else if (out_valid) begin
            frame_count <= frame_count + 1;
            last_left   <= out_left | (out_right & 24'h0);
        end
    end
endmodule
`default_nettype wire

// ==== verif/avmd_volume_detect_tb_top.sv ====
// Self-checking bench of the volume, soft mute and presence detection block
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module avmd_volume_detect_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [2:0] slope; int n; logic [7:0] gain;} avmd_row_type;
    // Fade pace table: samples per step; reserved codes pace as 16, direct jumps
    avmd_row_type rows [7] = '{'{3'h0, 1, 8'h01}, '{3'h1, 2, 8'h01}, '{3'h2, 4, 8'h01},
        '{3'h3, 8, 8'h01}, '{3'h4, 16, 8'h01}, '{3'h5, 16, 8'h01}, '{3'h7, 1, 8'h02}};
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic        conv_active = 1'b0;
    logic        adc_valid = 1'b0;
    logic [23:0] adc_left = 24'h0;
    logic [23:0] adc_right = 24'h0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, out_valid, presence_flag_out;
    logic [23:0] out_left, out_right, last_left;
    logic [1:0]  converter_operation_mode;
    logic [2:0]  frontend_gain_select;
    int          errors = 0;
    int          check_count = 0;
    int          frame_count;
    int          sent = 0;
    always #25 sys_clk = ~sys_clk;
    avmd_volume_detect #(.HOLDOFF_SAMPLES(8), .DET_WINDOW(4)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .conv_active(conv_active), .adc_valid(adc_valid), .adc_left(adc_left),
        .adc_right(adc_right), .converter_operation_mode(converter_operation_mode),
        .frontend_gain_select(frontend_gain_select), .out_valid(out_valid),
        .out_left(out_left), .out_right(out_right), .presence_flag_out(presence_flag_out));
    avmd_sink sink (.sys_clk(sys_clk), .nrst(nrst), .out_valid(out_valid),
        .out_left(out_left), .out_right(out_right), .frame_count(frame_count),
        .last_left(last_left));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ctrl(input logic [7:0] v, input logic [2:0] s,
                                         input logic m, input logic p, input logic t);
        return {13'h0, 3'h3, 2'h0, t, p, m, s, v};
    endfunction
    // Request held until the edge that samples waitrequest low; data taken there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    // One stereo sample, then idle cycles so the two-cycle pipeline drains
    task automatic smp(input logic [23:0] v);
        @(posedge sys_clk);
        adc_valid <= 1'b1;
        adc_left  <= v;
        adc_right <= -v;
        @(posedge sys_clk);
        adc_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        sent += int'(conv_active);
    endtask
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        nrst        <= 1'b1;
        conv_active <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        `CHK(rd, 32'h0003_0000)
        `CHK(frontend_gain_select, 3'h3)
        bus(1'b1, 4'h4, 32'hffff_ffff);
        bus(1'b0, 4'h4, 32'h0);
        `CHK(rd, 32'h0000_00ff)
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(1'b0, 4'hc, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, 4'h4, 32'h0);
        $display("Test registers done");
        foreach (rows[i]) begin
            bus(1'b1, 4'h0, ctrl(8'h00, 3'h7, 1'b0, 1'b0, 1'b1));
            smp(24'h000100);
            bus(1'b1, 4'h0, ctrl(8'h02, rows[i].slope, 1'b0, 1'b0, 1'b1));
            repeat (rows[i].n - 1) smp(24'h000100);
            bus(1'b0, 4'h8, 32'h0);
            `CHK(rd[15:8], 8'h00)
            smp(24'h000100);
            bus(1'b0, 4'h8, 32'h0);
            `CHK(rd[15:8], rows[i].gain)
        end
        $display("Test fade slopes done");
        bus(1'b1, 4'h0, ctrl(8'h00, 3'h7, 1'b1, 1'b0, 1'b1));
        smp(24'h123456);
        smp(24'h123456);
        bus(1'b0, 4'h8, 32'h0);
        `CHK(rd[15:8], 8'hff)
        `CHK(out_left, 24'h0)
        `CHK(out_right, 24'h0)
        `CHK(last_left, 24'h0)
        bus(1'b1, 4'h0, ctrl(8'h00, 3'h7, 1'b0, 1'b0, 1'b1));
        smp(24'h000100);
        bus(1'b1, 4'h0, ctrl(8'h00, 3'h0, 1'b1, 1'b0, 1'b1));
        smp(24'h000100);
        smp(24'h000100);
        bus(1'b1, 4'h0, ctrl(8'h00, 3'h0, 1'b0, 1'b0, 1'b1));
        smp(24'h000100);
        bus(1'b0, 4'h8, 32'h0);
        `CHK({rd[15:8], rd[3:2]}, {8'h01, 2'h2})
        bus(1'b1, 4'h0, ctrl(8'h00, 3'h0, 1'b1, 1'b0, 1'b1));
        smp(24'h000100);
        bus(1'b0, 4'h8, 32'h0);
        `CHK({rd[15:8], rd[3:2]}, {8'h02, 2'h1})
        `CHK(frame_count, sent)
        $display("Test soft mute done");
        `CHK(presence_flag_out, 1'b1)
        conv_active <= 1'b0;
        smp(24'h200000);
        `CHK(presence_flag_out, 1'b0)
        `CHK(frame_count, sent)
        conv_active <= 1'b1;
        for (int i = 0; i < 4; i++) smp(i[0] ? 24'h200000 : 24'he00000);
        bus(1'b0, 4'h8, 32'h0);
        `CHK({presence_flag_out, rd[1]}, 2'b00)
        for (int i = 0; i < 12; i++) smp(i[0] ? 24'h200000 : 24'he00000);
        bus(1'b0, 4'h8, 32'h0);
        `CHK({presence_flag_out, rd[1:0]}, 3'b111)
        bus(1'b1, 4'h0, ctrl(8'h00, 3'h0, 1'b0, 1'b1, 1'b1));
        bus(1'b0, 4'h8, 32'h0);
        `CHK({presence_flag_out, rd[0]}, 2'b00)
        bus(1'b1, 4'h0, ctrl(8'h00, 3'h0, 1'b0, 1'b0, 1'b0));
        for (int i = 0; i < 5; i++) smp(i[0] ? 24'h200000 : 24'he00000);
        `CHK(presence_flag_out, 1'b1)
        $display("Test presence detection done");
        // Bench plays clock master with the receiver stopped, so low-rate mode is legal
        bus(1'b1, 4'h0, 32'h0003_8000);
        smp(24'h200000);
        bus(1'b0, 4'h8, 32'h0);
        `CHK({presence_flag_out, rd[16], converter_operation_mode}, 4'h2)
        bus(1'b1, 4'h0, 32'h0003_a000);
        for (int i = 0; i < 4; i++) smp(i[0] ? 24'h200000 : 24'he00000);
        `CHK(presence_flag_out, 1'b1)
        nrst <= 1'b0;
        @(posedge sys_clk);
        `CHK({presence_flag_out, out_valid, out_left, avs_readdata}, 58'h0)
        nrst <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        `CHK(rd, 32'h0003_0000)
        $display("Test low-rate and mid-run reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
